//--- design/can_rx_store_pkg.sv
// Constants for the receive-store and autobaud block
package can_rx_store_pkg;
  localparam int NUM_CENTERS = 15;
  localparam int ID_W = 29;
  localparam int DATA_W = 64;
  localparam int DLC_W = 4;
  localparam int ERR_W = 8;
  localparam int SHADOW_CENTER = 15;
  // Register map
  localparam logic [7:0] CAN_STATUS_ADDR = 8'hA4;
  localparam logic [7:0] CAN_CONTROL_ADDR = 8'hA3;
  // Control register fields
  localparam int CTL_SWINIT_BIT = 0;
  localparam int CTL_MODRST_BIT = 3;
  localparam int CTL_AUTOBAUD_BIT = 2;
  localparam logic [7:0] CTL_RESET = 8'h01;
  // Status register fields
  localparam int STS_ECNT_BIT = 6;
  localparam int STS_BUSOFF_BIT = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // Error counting
  localparam logic [ERR_W-1:0] ERR_RESET = 8'h00;
  localparam logic [ERR_W-1:0] ERR_THRESHOLD = 8'h60;
  localparam logic [ERR_W-1:0] ERR_STEP_SMALL = 8'h01;
  localparam logic [ERR_W-1:0] ERR_STEP_LARGE = 8'h08;
  localparam logic [ERR_W-1:0] ERR_MAX = 8'hFF;
endpackage

//--- design/rx_center_select.sv
// Picks the lowest-numbered eligible receive center for an incoming frame
`timescale 1ns/100ps
`default_nettype none
module rx_center_select #(
  parameter int N = 14
) (
  // Per-center state
  input wire logic [N-1:0] id_match,
  input wire logic [N-1:0] busy,
  input wire logic [N-1:0] overwrite_enable,
  // Result
  output logic found,
  output logic [N-1:0] onehot,
  output logic overwrite
);
  logic [N-1:0] eligible;
  logic [N-1:0] free_set;
  logic [N-1:0] ow_set;

  function automatic logic [N-1:0] lowest(input logic [N-1:0] v);
    logic [N-1:0] r;
    r = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = '0;
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction

  always_comb begin
    free_set = id_match & ~busy;
    ow_set = id_match & busy & overwrite_enable;
    eligible = free_set | ow_set;
    found = |eligible;
    // Lowest eligible center wins, free or overwritable alike
    onehot = lowest(eligible);
    overwrite = |(onehot & busy);
  end
endmodule
`default_nettype wire

//--- design/can_rx_store_autobaud.sv
// Receive message storage, center 15 shadow buffer and autobaud listen mode
`timescale 1ns/100ps
`default_nettype none
module can_rx_store_autobaud
  import can_rx_store_pkg::*;
#(
  parameter int CENTERS = NUM_CENTERS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Per-center configuration from software
  input wire logic [CENTERS*can_rx_store_pkg::ID_W-1:0] arbitration_value,
  input wire logic [CENTERS-1:0] overwrite_enable,
  input wire logic [CENTERS-1:0] rx_center_enable,
  // Software flag clears and engine remote request sets, one pulse per center
  input wire logic [CENTERS-1:0] clear_data_updated,
  input wire logic [CENTERS-1:0] clear_pending_remote_request,
  input wire logic [CENTERS-1:0] set_pending_remote_request,
  // Received frame from the protocol engine
  input wire logic frame_valid,
  input wire logic [can_rx_store_pkg::ID_W-1:0] frame_id,
  input wire logic [can_rx_store_pkg::DLC_W-1:0] frame_dlc,
  input wire logic [can_rx_store_pkg::DATA_W-1:0] frame_data,
  // Protocol engine errors and transmit bit
  input wire logic rx_error,
  input wire logic rx_error_large,
  input wire logic tx_error,
  input wire logic engine_tx,
  // Bus pins
  input wire logic can_rx_pin,
  output logic can_tx_pin,
  // Receiver bit stream and module state
  output logic engine_rx,
  output logic bus_enable,
  // Stored centers
  output logic [CENTERS-1:0] data_updated,
  output logic [CENTERS-1:0] pending_remote_request,
  output logic [CENTERS-1:0] rx_overwrite,
  output logic [CENTERS*can_rx_store_pkg::ID_W-1:0] center_id,
  output logic [CENTERS*can_rx_store_pkg::DLC_W-1:0] center_dlc,
  output logic [CENTERS*can_rx_store_pkg::DATA_W-1:0] center_data,
  // Error counters
  output logic [can_rx_store_pkg::ERR_W-1:0] rx_error_counter,
  output logic [can_rx_store_pkg::ERR_W-1:0] tx_error_counter
);
  import can_rx_store_pkg::*;

  // Centers 1 to 14 go through the selector; the last one has a shadow
  localparam int LOW = CENTERS - 1;
  localparam int TOP = CENTERS - 1;

  logic [7:0] can_control_reg;
  logic error_count_exceeded;
  logic [ID_W-1:0] shadow_id;
  logic [DLC_W-1:0] shadow_dlc;
  logic [DATA_W-1:0] shadow_data;
  logic shadow_full;
  logic [CENTERS-1:0] id_hit;
  logic [CENTERS-1:0] busy;
  logic sel_found;
  logic [LOW-1:0] sel_onehot;
  logic sel_overwrite;
  logic [CENTERS-1:0] store;
  logic top_direct;
  logic top_to_shadow;
  logic top_shadow_ow;
  logic shadow_move;
  logic autobaud;
  logic software_init_bit;

  // Saturating add so counters stop at the top instead of wrapping
  function automatic logic [ERR_W-1:0] sat_add(input logic [ERR_W-1:0] a,
                                              input logic [ERR_W-1:0] b);
    logic [ERR_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[ERR_W] ? ERR_MAX : s[ERR_W-1:0];
  endfunction

  assign autobaud = can_control_reg[CTL_AUTOBAUD_BIT];
  assign software_init_bit = can_control_reg[CTL_SWINIT_BIT];

  // Match and occupancy per center
  always_comb begin
    for (int i = 0; i < CENTERS; i++) begin
      id_hit[i] = rx_center_enable[i] && (arbitration_value[i*ID_W +: ID_W] == frame_id);
      busy[i] = data_updated[i] | pending_remote_request[i];
    end
  end

  rx_center_select #(
    .N(LOW)
  ) u_select (
    .id_match(id_hit[LOW-1:0]),
    .busy(busy[LOW-1:0]),
    .overwrite_enable(overwrite_enable[LOW-1:0]),
    .found(sel_found),
    .onehot(sel_onehot),
    .overwrite(sel_overwrite)
  );

  // Routing decision; center 15 is only used when no lower center takes it
  always_comb begin
    logic take;
    take = frame_valid && !software_init_bit;
    store = '0;
    top_direct = 1'b0;
    top_to_shadow = 1'b0;
    top_shadow_ow = 1'b0;
    // Shadow drains first, so a new frame never overtakes it
    shadow_move = shadow_full && !busy[TOP];
    if (take && sel_found) begin
      store[LOW-1:0] = sel_onehot;
    end else if (take && id_hit[TOP]) begin
      if (!busy[TOP] && !shadow_full) begin
        top_direct = 1'b1;
      end else if (!busy[TOP]) begin
        // Center takes the old shadow, the new frame refills it
        top_to_shadow = 1'b1;
      end else if (!shadow_full) begin
        top_to_shadow = 1'b1;
      end else if (overwrite_enable[TOP]) begin
        top_to_shadow = 1'b1;
        top_shadow_ow = 1'b1;
      end
      // Otherwise discarded silently
    end
    store[TOP] = top_direct;
  end

  // Center contents
  // A shadow move and a direct store never fall in one cycle
  always_ff @(posedge clk) begin
    for (int i = 0; i < CENTERS; i++) begin
      if (store[i] || (i == TOP && shadow_move)) begin
        if (i == TOP && shadow_move) begin
          center_id[i*ID_W +: ID_W] <= shadow_id;
          center_dlc[i*DLC_W +: DLC_W] <= shadow_dlc;
          center_data[i*DATA_W +: DATA_W] <= shadow_data;
        end else begin
          center_id[i*ID_W +: ID_W] <= frame_id;
          center_dlc[i*DLC_W +: DLC_W] <= frame_dlc;
          center_data[i*DATA_W +: DATA_W] <= frame_data;
        end
      end
    end
    if (sys_rst) begin
      center_id <= '0;
      center_dlc <= '0;
      center_data <= '0;
    end
  end

  // Data-updated flags; a store wins over a simultaneous clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      data_updated <= '0;
    end else begin
      for (int i = 0; i < CENTERS; i++) begin
        if (store[i] || (i == TOP && shadow_move)) begin
          data_updated[i] <= 1'b1;
        end else if (clear_data_updated[i]) begin
          data_updated[i] <= 1'b0;
        end
      end
    end
  end

  // Pending remote request flags, set by the engine and cleared by software
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pending_remote_request <= '0;
    end else begin
      for (int i = 0; i < CENTERS; i++) begin
        if (set_pending_remote_request[i]) begin
          pending_remote_request[i] <= 1'b1;
        end else if (clear_pending_remote_request[i]) begin
          pending_remote_request[i] <= 1'b0;
        end
      end
    end
  end

  // Receive-overwrite flags
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_overwrite <= '0;
    end else begin
      for (int i = 0; i < LOW; i++) begin
        if (store[i] && sel_overwrite) begin
          rx_overwrite[i] <= 1'b1;
        end else if (clear_data_updated[i]) begin
          rx_overwrite[i] <= 1'b0;
        end
      end
      // Center 15 flags only shadow overwrites
      if (top_shadow_ow) begin
        rx_overwrite[TOP] <= 1'b1;
      end else if (clear_data_updated[TOP]) begin
        rx_overwrite[TOP] <= 1'b0;
      end
    end
  end

  // Shadow buffer of center 15
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shadow_full <= 1'b0;
      shadow_id <= '0;
      shadow_dlc <= '0;
      shadow_data <= '0;
    end else if (top_to_shadow) begin
      shadow_full <= 1'b1;
      shadow_id <= frame_id;
      shadow_dlc <= frame_dlc;
      shadow_data <= frame_data;
    end else if (shadow_move) begin
      shadow_full <= 1'b0;
    end
  end

  // Control register; module reset forces init and stops the bus
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      can_control_reg <= CTL_RESET;
    end else if (reg_wr && reg_addr == CAN_CONTROL_ADDR) begin
      can_control_reg <= reg_wdata;
      if (reg_wdata[CTL_MODRST_BIT]) begin
        can_control_reg[CTL_SWINIT_BIT] <= 1'b1;
      end
    end
  end

  // Bus participation follows the init and module reset bits
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bus_enable <= 1'b0;
    end else begin
      bus_enable <= !software_init_bit && !can_control_reg[CTL_MODRST_BIT];
    end
  end

  // Receive error counter, active only while on the bus
  always_ff @(posedge clk) begin
    if (sys_rst || can_control_reg[CTL_MODRST_BIT]) begin
      rx_error_counter <= ERR_RESET;
    end else if (bus_enable && rx_error) begin
      rx_error_counter <= sat_add(rx_error_counter,
                                  rx_error_large ? ERR_STEP_LARGE : ERR_STEP_SMALL);
    end
  end

  // Transmit error counter; transmit errors always step by eight
  always_ff @(posedge clk) begin
    if (sys_rst || can_control_reg[CTL_MODRST_BIT]) begin
      tx_error_counter <= ERR_RESET;
    end else if (bus_enable && tx_error) begin
      tx_error_counter <= sat_add(tx_error_counter, ERR_STEP_LARGE);
    end
  end

  // Exceeded flag, one cycle behind the counters
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      error_count_exceeded <= 1'b0;
    end else begin
      error_count_exceeded <= (rx_error_counter > ERR_THRESHOLD) ||
                              (tx_error_counter > ERR_THRESHOLD);
    end
  end

  // Transmit pin silenced to recessive in autobaud or off the bus
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      can_tx_pin <= 1'b1;
    end else begin
      can_tx_pin <= (autobaud || !bus_enable) ? 1'b1 : engine_tx;
    end
  end

  // Receiver input; autobaud loops the own transmit bit back in
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      engine_rx <= 1'b1;
    end else begin
      engine_rx <= autobaud ? (can_rx_pin & engine_tx) : can_rx_pin;
    end
  end

  // Register reads
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= STATUS_RESET;
    end else if (reg_rd) begin
      case (reg_addr)
        // Bit 7 shows the module off the bus
        CAN_STATUS_ADDR: begin
          reg_rdata <= STATUS_RESET;
          reg_rdata[STS_ECNT_BIT] <= error_count_exceeded;
          reg_rdata[STS_BUSOFF_BIT] <= !bus_enable;
        end
        CAN_CONTROL_ADDR: begin
          reg_rdata <= can_control_reg;
        end
        default: begin
          reg_rdata <= 8'h00;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

//--- sim/can_rx_store_checker.sv
// Concurrent checks on the ports of the receive-store and autobaud block
`timescale 1ns/100ps
`default_nettype none
module can_rx_store_checker
  import can_rx_store_pkg::*;
#(
  parameter int CENTERS = NUM_CENTERS
) (
  // Clock, reset and register port
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Centers and frames
  input wire logic [CENTERS*can_rx_store_pkg::ID_W-1:0] arbitration_value,
  input wire logic [CENTERS-1:0] overwrite_enable,
  input wire logic [CENTERS-1:0] rx_center_enable,
  input wire logic [CENTERS-1:0] clear_data_updated,
  input wire logic frame_valid,
  input wire logic [can_rx_store_pkg::ID_W-1:0] frame_id,
  input wire logic [CENTERS-1:0] data_updated,
  input wire logic [CENTERS-1:0] pending_remote_request,
  input wire logic [CENTERS-1:0] rx_overwrite,
  input wire logic [CENTERS*can_rx_store_pkg::DATA_W-1:0] center_data,
  // Pins and counters
  input wire logic engine_tx,
  input wire logic can_rx_pin,
  input wire logic can_tx_pin,
  input wire logic engine_rx,
  input wire logic [can_rx_store_pkg::ERR_W-1:0] rx_error_counter,
  input wire logic [can_rx_store_pkg::ERR_W-1:0] tx_error_counter
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic ab_q;
  logic mr_q;
  logic take0;
  // Mirror of the autobaud and module reset control bits
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ab_q <= 1'b0;
      mr_q <= 1'b0;
    end else if (reg_wr && reg_addr == CAN_CONTROL_ADDR) begin
      ab_q <= reg_wdata[CTL_AUTOBAUD_BIT];
      mr_q <= reg_wdata[CTL_MODRST_BIT];
    end
  end
  assign take0 = rx_center_enable[0] && arbitration_value[ID_W-1:0] == frame_id
    && (overwrite_enable[0] || !(data_updated[0] || pending_remote_request[0]));
  chk_tx_held_high: assert property (ab_q |=> can_tx_pin)
    else $error("tx pin not recessive in autobaud");
  chk_loop_and: assert property (ab_q |=>
    engine_rx == ($past(can_rx_pin) & $past(engine_tx))) else $error("loopback is not rx and tx");
  chk_cnt_cleared: assert property (mr_q |=> rx_error_counter == ERR_RESET
    && tx_error_counter == ERR_RESET) else $error("counters not cleared");
  chk_lowest_first: assert property ($rose(data_updated[1]) |-> $past(take0) == 1'b0)
    else $error("frame skipped the first center");
  chk_unmapped_zero: assert property (reg_rd && reg_addr != CAN_CONTROL_ADDR
    && reg_addr != CAN_STATUS_ADDR |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  for (genvar k = 0; k < CENTERS; k++) begin : g_c
    chk_ovw_cause: assert property ($rose(rx_overwrite[k]) |-> $past(overwrite_enable[k])
      && $past(frame_valid)) else $error("overwrite flag without cause");
    chk_no_clobber: assert property (frame_valid && !overwrite_enable[k]
      && (data_updated[k] || pending_remote_request[k]) && !clear_data_updated[k]
      |=> $stable(center_data[k*DATA_W +: DATA_W])) else $error("occupied center overwritten");
    if (k < CENTERS - 1) begin : g_d
      chk_dup_cause: assert property ($rose(data_updated[k]) |-> $past(frame_valid)
        && $past(frame_id) == $past(arbitration_value[k*ID_W +: ID_W]))
        else $error("data flag set without a matching frame");
    end
  end
  cover property ($rose(rx_overwrite[CENTERS-1]));
  cover property ($rose(data_updated[1]));
  cover property (ab_q && engine_rx == 1'b0);
endmodule
bind can_rx_store_autobaud can_rx_store_checker #(.CENTERS(CENTERS)) chk_u (
  .clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .arbitration_value(arbitration_value),
  .overwrite_enable(overwrite_enable), .rx_center_enable(rx_center_enable),
  .clear_data_updated(clear_data_updated), .frame_valid(frame_valid), .frame_id(frame_id),
  .data_updated(data_updated), .pending_remote_request(pending_remote_request),
  .rx_overwrite(rx_overwrite), .center_data(center_data), .engine_tx(engine_tx),
  .can_rx_pin(can_rx_pin), .can_tx_pin(can_tx_pin), .engine_rx(engine_rx),
  .rx_error_counter(rx_error_counter), .tx_error_counter(tx_error_counter)
);
`default_nettype wire

//--- sim/can_bus_node.sv
// Remote bus traffic seen by a listener at a mismatched bit rate
`timescale 1ns/100ps
`default_nettype none
module can_bus_node (
  // Clock and enable
  input wire logic clk,
  input wire logic active,
  // Bus line
  output logic rx
);
  integer seed = 26;
  initial rx = 1'b1;
  // Wrong-rate traffic looks random; an idle bus sits recessive
  always @(posedge clk) begin
    rx <= #1 active ? 1'($random(seed)) : 1'b1;
  end
endmodule
`default_nettype wire

//--- sim/can_rx_store_autobaud_test.sv
// Self-checking bench for the receive-store and autobaud block
`timescale 1ns/100ps
`default_nettype none
module can_rx_store_autobaud_test;
  import can_rx_store_pkg::*;
  localparam int C = NUM_CENTERS;
  localparam logic [ID_W-1:0] ID_A = 29'h0000123;
  localparam logic [ID_W-1:0] ID_B = 29'h0ABCDEF;
  typedef struct packed {
    logic [C-1:0] du;
    logic [C-1:0] ow;
    logic [ID_W-1:0] id;
    logic [DLC_W-1:0] dlc;
    logic [DATA_W-1:0] d;
  } exp_t;
  logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, probe = 1'b0, rs, ps;
  logic frame_valid = 1'b0, rx_error = 1'b0, rx_error_large = 1'b0, tx_error = 1'b0;
  logic engine_tx = 1'b1, listen = 1'b0, can_tx_pin, engine_rx, bus_enable;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [C*ID_W-1:0] arbitration_value = '0;
  logic [C-1:0] overwrite_enable = '0, rx_center_enable = '1, clr_du = '0, clr_pr = '0;
  logic [C-1:0] data_updated, pending_remote_request, rx_overwrite;
  logic [ID_W-1:0] frame_id = '0;
  logic [DLC_W-1:0] frame_dlc = '0;
  logic [DATA_W-1:0] frame_data = '0, e15, dd [7];
  logic [C*DATA_W-1:0] center_data;
  logic [C*ID_W-1:0] center_id;
  logic [C*DLC_W-1:0] center_dlc;
  logic [C-1:0] set_pr = '0;
  logic [ERR_W-1:0] rx_error_counter, tx_error_counter;
  wire can_rx_pin;
  logic [7:0] rd_q [$];
  exp_t st_q [$];
  integer errors = 0, n_compared = 0, seed = 26;
  always #4 clk = ~clk;
  can_bus_node peer_u (.clk(clk), .active(listen), .rx(can_rx_pin));
  can_rx_store_autobaud dut_u (
    .clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .arbitration_value(arbitration_value),
    .overwrite_enable(overwrite_enable), .rx_center_enable(rx_center_enable),
    .clear_data_updated(clr_du), .clear_pending_remote_request(clr_pr),
    .set_pending_remote_request(set_pr), .frame_valid(frame_valid), .frame_id(frame_id),
    .frame_dlc(frame_dlc), .frame_data(frame_data), .rx_error(rx_error),
    .rx_error_large(rx_error_large), .tx_error(tx_error), .engine_tx(engine_tx),
    .can_rx_pin(can_rx_pin), .can_tx_pin(can_tx_pin), .engine_rx(engine_rx),
    .bus_enable(bus_enable), .data_updated(data_updated),
    .pending_remote_request(pending_remote_request), .rx_overwrite(rx_overwrite),
    .center_id(center_id), .center_dlc(center_dlc), .center_data(center_data),
    .rx_error_counter(rx_error_counter), .tx_error_counter(tx_error_counter)
  );
  task automatic report_and_stop();
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_st(input exp_t got, input exp_t exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t store state %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    reg_addr = a;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    tick(1);
  endtask
  // Frame (fv high) or bare probe; state after the edge is compared
  task automatic op(input logic fv, input logic [ID_W-1:0] id, input logic [DATA_W-1:0] d,
                    input logic [C-1:0] du, input logic [C-1:0] ow);
    st_q.push_back({du, ow, ID_B, e15[DLC_W-1:0], e15});
    frame_id = id;
    frame_data = d;
    frame_dlc = d[DLC_W-1:0];
    frame_valid = fv;
    probe = 1'b1;
    tick(1);
    frame_valid = 1'b0;
    probe = 1'b0;
    tick(1);
  endtask
  task automatic clr(input int k);
    clr_du[k] = 1'b1;
    clr_pr[k] = 1'b1;
    tick(1);
    clr_du = '0;
    clr_pr = '0;
    tick(1);
  endtask
  always begin
    @(posedge clk);
    rs = reg_rd;
    ps = probe;
    #2;
    if (rs) cmp8(reg_rdata, rd_q.pop_front());
    if (ps) begin
      cmp_st({data_updated, rx_overwrite, center_id[(C-1)*ID_W +: ID_W],
              center_dlc[(C-1)*DLC_W +: DLC_W], center_data[(C-1)*DATA_W +: DATA_W]},
             st_q.pop_front());
    end
  end
  initial begin
    repeat (5000) @(posedge clk);
    $display("[ERR] %0t run timed out", $time);
    errors++;
    report_and_stop();
  end
  initial begin
    for (int k = 0; k < C; k++) begin
      arbitration_value[k*ID_W +: ID_W] = k < 2 ? ID_A : k == C - 1 ? ID_B : 29'h1555555;
    end
    for (int k = 0; k < 7; k++) dd[k] = {$random(seed), $random(seed)};
    tick(3);
    sys_rst = 1'b0;
    rd(CAN_CONTROL_ADDR, CTL_RESET);
    rd(8'h10, 8'h00);
    wr(CAN_CONTROL_ADDR, 8'h00);
    tick(1);
    e15 = dd[0];
    op(1'b1, ID_B, dd[0], 15'h4000, 15'h0000);
    op(1'b1, ID_B, dd[1], 15'h4000, 15'h0000);
    op(1'b1, ID_B, dd[2], 15'h4000, 15'h0000);
    clr(C - 1);
    e15 = dd[1];
    op(1'b0, ID_B, dd[0], 15'h4000, 15'h0000);
    clr(C - 1);
    op(1'b0, ID_B, dd[0], 15'h0000, 15'h0000);
    overwrite_enable[C-1] = 1'b1;
    e15 = dd[3];
    op(1'b1, ID_B, dd[3], 15'h4000, 15'h0000);
    op(1'b1, ID_B, dd[4], 15'h4000, 15'h0000);
    op(1'b1, ID_B, dd[5], 15'h4000, 15'h4000);
    clr(C - 1);
    e15 = dd[5];
    op(1'b0, ID_B, dd[0], 15'h4000, 15'h0000);
    clr(C - 1);
    set_pr[C-1] = 1'b1;
    tick(1);
    set_pr = '0;
    op(1'b1, ID_B, dd[6], 15'h0000, 15'h0000);
    clr(C - 1);
    e15 = dd[6];
    op(1'b0, ID_B, dd[0], 15'h4000, 15'h0000);
    clr(C - 1);
    op(1'b1, ID_A, dd[0], 15'h0001, 15'h0000);
    op(1'b1, ID_A, dd[1], 15'h0003, 15'h0000);
    op(1'b1, ID_A, dd[2], 15'h0003, 15'h0000);
    clr(0);
    op(1'b1, ID_A, dd[3], 15'h0003, 15'h0000);
    clr(0);
    clr(1);
    overwrite_enable[1:0] = 2'b11;
    op(1'b1, ID_A, dd[4], 15'h0001, 15'h0000);
    op(1'b1, ID_A, dd[5], 15'h0001, 15'h0001);
    clr(0);
    wr(CAN_CONTROL_ADDR, 8'h08);
    wr(CAN_CONTROL_ADDR, 8'h05);
    wr(CAN_CONTROL_ADDR, 8'h04);
    listen = 1'b1;
    tick(2);
    // Twelve large receive steps and one transmit step stay at the threshold
    for (int i = 0; i < 26; i++) begin
      engine_tx = 1'($random(seed));
      rx_error = i < 24 && !i[0];
      rx_error_large = i < 24 && !i[0];
      tx_error = i == 25;
      tick(1);
    end
    tx_error = 1'b0;
    tick(2);
    rd(CAN_STATUS_ADDR, 8'h00);
    rx_error = 1'b1;
    tick(1);
    rx_error = 1'b0;
    tick(2);
    rd(CAN_STATUS_ADDR, 8'h40);
    listen = 1'b0;
    wr(CAN_CONTROL_ADDR, 8'h08);
    tick(2);
    rd(CAN_STATUS_ADDR, 8'h80);
    rd(CAN_CONTROL_ADDR, 8'h09);
    op(1'b1, ID_A, dd[6], 15'h0000, 15'h0000);
    report_and_stop();
  end
endmodule
`default_nettype wire
